// >>> verilog/ikac_cfg.svh
// Function
// - after reset stay disabled, only configuration decode
// - strap low key method, high register method
// - key detector always armed unless strap high
// - finished key plus three selection reads load whole system configuration word
// - final FM selection read enables the device
// - non-DMA write aborts an unfinished key sequence
// - wrong non-DMA read returns detector to start
// - mixer configuration access blocked while audio disabled
// - audio base 220h-250h, else audio disabled
// - joystick base 200h-203h, else joystick disabled
// - FM base 388h-3B8h, else FM at 388h
`ifndef IKAC_CFG_SVH
`define IKAC_CFG_SVH

`define IKAC_ADDR_W      10
`define IKAC_KEY_LEN     7
`define IKAC_KEY_0       10'h22B
`define IKAC_KEY_1       10'h229
`define IKAC_KEY_2       10'h22F
`define IKAC_KEY_3       10'h22D
`define IKAC_KEY_4       10'h22D
`define IKAC_KEY_5       10'h22F
`define IKAC_KEY_6       10'h229
`define IKAC_AUD_LO      10'h220
`define IKAC_AUD_HI      10'h250
`define IKAC_AUD_STEP    10'h010
`define IKAC_JOY_LO      10'h200
`define IKAC_JOY_HI      10'h203
`define IKAC_FM_LO       10'h388
`define IKAC_FM_HI       10'h3B8
`define IKAC_FM_STEP     10'h010
`define IKAC_SCW_RESET   8'h00
`define IKAC_SCW_FM_POS  6
`define IKAC_SCW_JOY_POS 4
`define IKAC_SCW_JEN_BIT 3
`define IKAC_SCW_AEN_BIT 2
`define IKAC_SCW_AUD_POS 0

`endif

// >>> verilog/ikac_pkg.sv
package ikac_pkg;
    typedef enum logic [1:0] {
        IKAC_ST_KEY   = 2'b00,
        IKAC_ST_AUDIO = 2'b01,
        IKAC_ST_JOY   = 2'b10,
        IKAC_ST_FM    = 2'b11
    } ikac_state_t;

    typedef struct packed {
        ikac_state_t state;
        logic [2:0]  key_idx;
        logic [7:0]  pend_word;
        logic [7:0]  sys_config_word;
        logic        dev_enabled;
        logic        cfg_decode_only;
        logic        mixer_cfg_reach;
        logic        scr_method_sel;
    } ikac_core_t;

    typedef struct packed {
        logic [2:0]  rd_hist;
        logic [2:0]  wr_hist;
        logic [1:0]  dma_sync;
        logic [1:0]  strap_sync;
        logic [19:0] addr_sync;
        logic        rd_pulse;
        logic        wr_pulse;
    } ikac_sync_t;
endpackage

// >>> verilog/ikac_bus_if.sv
`timescale 1ns/1ps
interface ikac_bus_if;
    logic       rd_pulse;
    logic       wr_pulse;
    logic       dma_cycle;
    logic       strap;
    logic [9:0] addr;

    modport src (output rd_pulse, output wr_pulse, output dma_cycle, output strap, output addr);
    modport dst (input rd_pulse, input wr_pulse, input dma_cycle, input strap, input addr);
endinterface

// >>> verilog/ikac_bus_sync.sv
`timescale 1ns/1ps
`include "ikac_cfg.svh"
module ikac_bus_sync (
    input  wire logic                       clock,    // 200 MHz
    input  wire logic                       sys_rst,  // async, high
    input  wire logic [`IKAC_ADDR_W-1:0]    isa_addr, // pin address
    input  wire logic                       ior_n,    // pin read strobe
    input  wire logic                       iow_n,    // pin write strobe
    input  wire logic                       isa_aen,  // pin DMA cycle
    input  wire logic                       strap_in, // pin strap
    ikac_bus_if.src                         bus       // synchronised events
);
    import ikac_pkg::*;

    ikac_sync_t r;
    ikac_sync_t next_r;

    always_comb begin
        next_r            = r;
        next_r.rd_hist    = {r.rd_hist[1:0], ~ior_n};
        next_r.wr_hist    = {r.wr_hist[1:0], ~iow_n};
        next_r.dma_sync   = {r.dma_sync[0], isa_aen};
        next_r.strap_sync = {r.strap_sync[0], strap_in};
        next_r.addr_sync  = {r.addr_sync[9:0], isa_addr};
        // edge taken on stages two and three; stage one feeds stage two only
        next_r.rd_pulse   = r.rd_hist[1] & ~r.rd_hist[2];
        next_r.wr_pulse   = r.wr_hist[1] & ~r.wr_hist[2];
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // address settles long before the strobe, so the pulse lines up with it
    assign bus.rd_pulse  = r.rd_pulse;
    assign bus.wr_pulse  = r.wr_pulse;
    assign bus.dma_cycle = r.dma_sync[1];
    assign bus.strap     = r.strap_sync[1];
    assign bus.addr      = r.addr_sync[19:10];
endmodule

// >>> verilog/ikac_top.sv
`timescale 1ns/1ps
`include "ikac_cfg.svh"
module ikac_top (
    input  wire logic                    clock,                  // 200 MHz
    input  wire logic                    sys_rst,                // async, high
    input  wire logic [`IKAC_ADDR_W-1:0] isa_addr,               // I/O address
    input  wire logic                    ior_n,                  // read strobe, low
    input  wire logic                    iow_n,                  // write strobe, low
    input  wire logic                    isa_aen,                // DMA cycle marker
    input  wire logic                    addr_config_mode_strap, // method strap
    output logic [7:0]                   sys_config_word,        // loaded config
    output logic                         dev_enabled,            // key and selection reads done
    output logic                         cfg_decode_only,        // only config decode live
    output logic                         mixer_cfg_reach,        // mixer config reachable
    output logic                         scr_method_sel          // register method chosen
);
    import ikac_pkg::*;

    ikac_bus_if bus ();

    ikac_bus_sync u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .isa_addr (isa_addr),
        .ior_n    (ior_n),
        .iow_n    (iow_n),
        .isa_aen  (isa_aen),
        .strap_in (addr_config_mode_strap),
        .bus      (bus)
    );

    function automatic logic [9:0] key_addr(input logic [2:0] idx);
        case (idx)
            3'h0:    key_addr = `IKAC_KEY_0;
            3'h1:    key_addr = `IKAC_KEY_1;
            3'h2:    key_addr = `IKAC_KEY_2;
            3'h3:    key_addr = `IKAC_KEY_3;
            3'h4:    key_addr = `IKAC_KEY_4;
            3'h5:    key_addr = `IKAC_KEY_5;
            default: key_addr = `IKAC_KEY_6;
        endcase
    endfunction

    ikac_core_t r;
    ikac_core_t next_r;

    logic       rd_ev;
    logic       wr_ev;
    logic       aud_ok;
    logic       joy_ok;
    logic       fm_ok;
    logic [9:0] aud_off;
    logic [9:0] fm_off;

    // DMA cycles are invisible to the detector
    assign rd_ev   = bus.rd_pulse & ~bus.dma_cycle;
    assign wr_ev   = bus.wr_pulse & ~bus.dma_cycle;
    assign aud_off = bus.addr - `IKAC_AUD_LO;
    assign fm_off  = bus.addr - `IKAC_FM_LO;
    assign aud_ok  = (bus.addr >= `IKAC_AUD_LO) && (bus.addr <= `IKAC_AUD_HI)
                     && (aud_off[3:0] == 4'h0);
    assign joy_ok  = (bus.addr >= `IKAC_JOY_LO) && (bus.addr <= `IKAC_JOY_HI);
    assign fm_ok   = (bus.addr >= `IKAC_FM_LO) && (bus.addr <= `IKAC_FM_HI)
                     && (fm_off[3:0] == 4'h0);

    always_comb begin
        next_r                = r;
        next_r.scr_method_sel = bus.strap;
        if (bus.strap) begin
            // register method owns configuration; key tracking held at start
            next_r.state   = IKAC_ST_KEY;
            next_r.key_idx = 3'h0;
        end else if (wr_ev) begin
            next_r.state   = IKAC_ST_KEY;
            next_r.key_idx = 3'h0;
        end else if (rd_ev) begin
            case (r.state)
                IKAC_ST_KEY: begin
                    if (bus.addr == key_addr(r.key_idx)) begin
                        if (r.key_idx == 3'(`IKAC_KEY_LEN - 1)) begin
                            next_r.state   = IKAC_ST_AUDIO;
                            next_r.key_idx = 3'h0;
                        end else begin
                            next_r.key_idx = r.key_idx + 3'h1;
                        end
                    end else begin
                        next_r.key_idx = 3'h0;
                    end
                end
                IKAC_ST_AUDIO: begin
                    next_r.pend_word = `IKAC_SCW_RESET;
                    if (aud_ok) begin
                        next_r.pend_word[`IKAC_SCW_AUD_POS +: 2] = aud_off[5:4];
                        next_r.pend_word[`IKAC_SCW_AEN_BIT]      = 1'b1;
                    end
                    next_r.state = IKAC_ST_JOY;
                end
                IKAC_ST_JOY: begin
                    if (joy_ok) begin
                        next_r.pend_word[`IKAC_SCW_JOY_POS +: 2] = bus.addr[1:0];
                        next_r.pend_word[`IKAC_SCW_JEN_BIT]      = 1'b1;
                    end
                    next_r.state = IKAC_ST_FM;
                end
                IKAC_ST_FM: begin
                    next_r.sys_config_word = r.pend_word;
                    next_r.sys_config_word[`IKAC_SCW_FM_POS +: 2] = fm_ok ? fm_off[5:4] : 2'b00;
                    next_r.dev_enabled     = 1'b1;
                    next_r.state           = IKAC_ST_KEY;
                    next_r.key_idx         = 3'h0;
                end
                default: begin
                    next_r.state   = IKAC_ST_KEY;
                    next_r.key_idx = 3'h0;
                end
            endcase
        end
        next_r.cfg_decode_only = ~next_r.dev_enabled;
        // mixer configuration reach lives behind the audio decode
        next_r.mixer_cfg_reach = next_r.dev_enabled & next_r.sys_config_word[`IKAC_SCW_AEN_BIT];
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            r                 <= '0;
            r.state           <= IKAC_ST_KEY;
            r.sys_config_word <= `IKAC_SCW_RESET;
            r.cfg_decode_only <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign sys_config_word = r.sys_config_word;
    assign dev_enabled     = r.dev_enabled;
    assign cfg_decode_only = r.cfg_decode_only;
    assign mixer_cfg_reach = r.mixer_cfg_reach;
    assign scr_method_sel  = r.scr_method_sel;
endmodule

// >>> testbench/ikac_top_properties.sv
`timescale 1ns/1ps
module ikac_top_props (
    input wire logic       clock,                  // clk
    input wire logic       sys_rst,                // rst
    input wire logic       ior_n,                  // rd
    input wire logic       addr_config_mode_strap, // strap
    input wire logic [7:0] sys_config_word,        // word
    input wire logic       dev_enabled,            // en
    input wire logic       cfg_decode_only,        // cfg
    input wire logic       mixer_cfg_reach,        // mix
    input wire logic       scr_method_sel          // sel
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // 4..5 edges back: async strobe sampling adds one edge of jitter
    a_rise_on_read: assert property ($rose(dev_enabled) |-> !$past(ior_n, 4) || !$past(ior_n, 5))
        else $error("enable without read");
    a_word_on_read: assert property ($changed(sys_config_word) |-> !$past(ior_n, 4) || !$past(ior_n, 5))
        else $error("word moved without read");
    a_word_with_en: assert property ($changed(sys_config_word) |-> dev_enabled)
        else $error("word moved while disabled");
    a_en_sticky: assert property (!$fell(dev_enabled))
        else $error("enable dropped");
    a_cfg_only: assert property (cfg_decode_only == !dev_enabled)
        else $error("decode state wrong");
    a_mixer_gate: assert property (mixer_cfg_reach == (dev_enabled && sys_config_word[2]))
        else $error("mixer reach wrong");
    a_aud_off: assert property (!sys_config_word[2] |-> sys_config_word[1:0] == 2'h0)
        else $error("audio field set");
    a_joy_off: assert property (!sys_config_word[3] |-> sys_config_word[5:4] == 2'h0)
        else $error("joystick field set");
    a_strap_sel: assert property ($rose(addr_config_mode_strap) |-> ##[1:4] scr_method_sel)
        else $error("strap not seen");
    a_strap_hold: assert property (scr_method_sel [*6] |=> !$rose(dev_enabled))
        else $error("enabled under strap");
    c_enable: cover property ($rose(dev_enabled));
    c_strap: cover property (scr_method_sel [*6]);
    c_aud_off: cover property (dev_enabled && !sys_config_word[2]);
endmodule

bind ikac_top ikac_top_props ikac_top_props_i (.clock, .sys_rst, .ior_n, .addr_config_mode_strap,
    .sys_config_word, .dev_enabled, .cfg_decode_only, .mixer_cfg_reach, .scr_method_sel);

// >>> testbench/ikac_host_model.sv
`timescale 1ns/1ps
module ikac_host_model (
    input  wire logic       clock,    // bus clock
    output logic      [9:0] isa_addr, // address
    output logic            ior_n,    // read strobe
    output logic            iow_n,    // write strobe
    output logic            isa_aen   // dma marker
);
    initial begin
        isa_addr = 10'h000;
        ior_n    = 1'b1;
        iow_n    = 1'b1;
        isa_aen  = 1'b0;
    end
    // strobe 4 clocks low, at least 5 high: above the 3-clock minimum
    task automatic cyc(input logic [9:0] a, input logic wr, input logic dma);
        @(posedge clock) #1;
        isa_addr = a;
        isa_aen  = dma;
        @(posedge clock) #1;
        if (wr) begin
            iow_n = 1'b0;
        end else begin
            ior_n = 1'b0;
        end
        repeat (4) @(posedge clock);
        #1;
        ior_n = 1'b1;
        iow_n = 1'b1;
        @(posedge clock) #1;
        isa_addr = ~a; // released bus must not show a stale address
        isa_aen  = 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic key(input logic [9:0] a, j, f, input int at, input logic [9:0] x, input logic xw, xd);
        logic [9:0] s [11];
        s = '{10'h300, 10'h22B, 10'h229, 10'h22F, 10'h22D, 10'h22D, 10'h22F, 10'h229, a, j, f};
        for (int i = 0; i < 11; i++) begin
            if (i == at) begin
                cyc(x, xw, xd);
            end
            cyc(s[i], 1'b0, 1'b0);
        end
    endtask
endmodule

// >>> testbench/ikac_top_tb.sv
`timescale 1ns/1ps
module ikac_top_tb;
    logic       clock;
    logic       sys_rst;
    logic       strap;
    logic [9:0] isa_addr;
    logic       ior_n, iow_n, isa_aen;
    logic [7:0] word;
    logic       en, dec, mix, sel;
    int         miscompares, num_checks, cycles;
    ikac_top ikac_top_i (.clock(clock), .sys_rst(sys_rst), .isa_addr(isa_addr), .ior_n(ior_n),
        .iow_n(iow_n), .isa_aen(isa_aen), .addr_config_mode_strap(strap), .sys_config_word(word),
        .dev_enabled(en), .cfg_decode_only(dec), .mixer_cfg_reach(mix), .scr_method_sel(sel));
    ikac_host_model ikac_host_model_i (.clock(clock), .isa_addr(isa_addr), .ior_n(ior_n),
        .iow_n(iow_n), .isa_aen(isa_aen));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic end_sim;
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic rst;
        @(posedge clock) #1;
        sys_rst = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic t_codes;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            ikac_host_model_i.key(10'h220 + 10'({c, 4'h0}), 10'h200 + 10'(c), 10'h388 + 10'({c, 4'h0}),
                -1, 10'h000, 1'b0, 1'b0);
            chk(word, {c, c, 2'b11, c});
            chk({5'h0, en, dec, mix}, 8'h05);
        end
    endtask
    task automatic t_bad;
        rst();
        ikac_host_model_i.key(10'h221, 10'h204, 10'h389, -1, 10'h000, 1'b0, 1'b0);
        chk(word, 8'h00);
        chk({5'h0, en, dec, mix}, 8'h04);
        ikac_host_model_i.key(10'h250, 10'h1FF, 10'h3C8, -1, 10'h000, 1'b0, 1'b0);
        chk(word, 8'h07);
    endtask
    task automatic t_abort;
        int         at [5] = '{5, 9, 5, 3, 3};
        logic [9:0] xa [5] = '{10'h22B, 10'h300, 10'h22B, 10'h22D, 10'h300};
        logic       xw [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        logic       xd [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 5; i++) begin
            rst();
            ikac_host_model_i.key(10'h230, 10'h202, 10'h398, at[i], xa[i], xw[i], xd[i]);
            chk(word, xd[i] ? 8'h6D : 8'h00);
        end
    endtask
    task automatic t_strap;
        rst();
        @(posedge clock) #1;
        strap = 1'b1;
        repeat (5) @(posedge clock);
        chk({7'h0, sel}, 8'h01);
        ikac_host_model_i.key(10'h230, 10'h202, 10'h398, -1, 10'h000, 1'b0, 1'b0);
        chk({word[6:0], en}, 8'h00);
        #1;
        strap = 1'b0;
        repeat (5) @(posedge clock);
        ikac_host_model_i.key(10'h230, 10'h202, 10'h398, -1, 10'h000, 1'b0, 1'b0);
        chk({sel, en, word[5:0]}, 8'h6D);
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        strap   = 1'b0;
        sys_rst = 1'b1;
        rst();
        chk(word, 8'h00);
        chk({4'h0, en, dec, mix, sel}, 8'h04);
        t_codes();
        t_bad();
        t_abort();
        t_strap();
        end_sim();
    end
endmodule
